// >>> rtl/mcal_core.sv
// Purpose: calibration of current, temperature and voltage readings
// Assumes: raw conversions arrive on core_clk with one-cycle done pulses
// Notes: APB slave, zero wait states, registers on word index times four
`timescale 1ns/100ps
`include "mcal_map.svh"

////////////////////////////////////////////////////////////////////
// How it works
// (R1) Positive sense voltage means charging; sign carried into current result.
// (R2) Raw current word spans +-51.2 mV at 1.5625 uV per step.
// (R3) Current equals raw times gain over 0x400 plus offset.
// (R4) Current gain resets to 0x0400, offset to 0x0000.
// (R5) Nonzero temperature coefficient enables temperature scaling; zero disables it.
// (R6) Coefficient step is 3.1224/0x10000 percent per degree.
// (R7) Host writes 0x20C8 for copper trace sensing.
// (R8) Copper compensation uses die temperature plus metal-trace self-heating curve.
// (R9) Curvature register: upper byte metal trace, lower byte thermistor.
// (R10) Only one temperature path, internal or external, runs at once.
// (R11) Thermistor ratio stored 0 to 100 percent, 0.0122 percent per step.
// (R12) External temperature uses gain, offset and thermistor curvature.
// (R13) Internal temperature bypasses gain, offset and curvature.
// (R14) Temperature gain resets to 0xEE56, offset to 0x1DA4.
// (R15) Battery voltage is battery pin minus positive sense pin.
// (R16) Host divides current values by sense resistance for amperes.
// (R17) Current result is signed, 1.5625 uV per step.
// (R18) Temperature result is signed, 1/256 degree per step.
// (R19) Results recomputed on every completed conversion with present settings.
module mcal_core
  import mcal_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [15:0] current_raw,
  input wire logic current_done,
  input wire logic signed [15:0] die_temp_raw,
  input wire logic die_temp_done,
  input wire logic [15:0] ratio_raw,
  input wire logic ratio_done,
  input wire logic [15:0] battery_voltage_pin,
  input wire logic [15:0] sense_pos_pin,
  input wire logic voltage_done,
  output logic temp_path_ext,
  output logic signed [15:0] current_result,
  output logic signed [15:0] temperature_result,
  output logic [15:0] voltage_result
);

  ////////////////////////////////////////////////////////////////////
  // Register storage
  mcal_word_t temperature_gain;
  mcal_word_t temperature_offset;
  mcal_word_t current_gain;
  mcal_word_t current_offset;
  mcal_word_t current_temp_coefficient;
  mcal_word_t curvature_correction;
  mcal_word_t thermistor_ratio_result;
  mcal_path_t temp_path;
  logic signed [15:0] die_temp;

  ////////////////////////////////////////////////////////////////////
  // APB decode; index is the word address
  logic [7:0] reg_idx;
  logic addr_aligned;
  logic hit_temp_res;
  logic hit_volt_res;
  logic hit_cur_res;
  logic hit_config;
  logic hit_ratio;
  logic hit_temperature_gain;
  logic hit_toff;
  logic hit_current_gain;
  logic hit_current_offset;
  logic hit_tempco;
  logic hit_curve;
  logic hit_any;
  logic wr_ok;
  logic setup_phase;
  mcal_word_t rd_word;

  assign reg_idx = paddr[9:2];
  assign addr_aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign hit_temp_res = addr_aligned && (reg_idx == `MCAL_IDX_TEMP_RES);
  assign hit_volt_res = addr_aligned && (reg_idx == `MCAL_IDX_VOLT_RES);
  assign hit_cur_res = addr_aligned && (reg_idx == `MCAL_IDX_CUR_RES);
  assign hit_config = addr_aligned && (reg_idx == `MCAL_IDX_CONFIG);
  assign hit_ratio = addr_aligned && (reg_idx == `MCAL_IDX_RATIO);
  assign hit_temperature_gain = addr_aligned && (reg_idx == `MCAL_IDX_TEMPERATURE_GAIN);
  assign hit_toff = addr_aligned && (reg_idx == `MCAL_IDX_TOFF);
  assign hit_current_gain = addr_aligned && (reg_idx == `MCAL_IDX_CURRENT_GAIN);
  assign hit_current_offset = addr_aligned && (reg_idx == `MCAL_IDX_CURRENT_OFFSET);
  assign hit_tempco = addr_aligned && (reg_idx == `MCAL_IDX_TEMPCO);
  assign hit_curve = addr_aligned && (reg_idx == `MCAL_IDX_CURVE);
  assign hit_any = hit_temp_res | hit_volt_res | hit_cur_res
    | hit_config | hit_ratio | hit_temperature_gain | hit_toff | hit_current_gain
    | hit_current_offset | hit_tempco | hit_curve;

  // No wait states; unmapped access answered with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_any;
  assign setup_phase = psel && !penable;
  assign wr_ok = psel && penable && pwrite && hit_any;

  // Read mux; result registers read back live state
  assign rd_word =
    hit_temp_res ? mcal_word_t'(temperature_result) :
    hit_volt_res ? voltage_result :
    hit_cur_res ? mcal_word_t'(current_result) :
    hit_config ? {15'h0000, temp_path} :
    hit_ratio ? thermistor_ratio_result :
    hit_temperature_gain ? temperature_gain :
    hit_toff ? temperature_offset :
    hit_current_gain ? current_gain :
    hit_current_offset ? current_offset :
    hit_tempco ? current_temp_coefficient :
    hit_curve ? curvature_correction : 16'h0000;

  // Read data captured in setup so it comes from a flop
  always_ff @(posedge core_clk)
  begin
    if (srst)
      prdata <= 32'h0000_0000;
    else if (setup_phase && !pwrite)
      prdata <= {16'h0000, rd_word};
  end

  ////////////////////////////////////////////////////////////////////
  // Writable registers; result and ratio words are read only
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      temperature_gain <= `MCAL_RST_TEMPERATURE_GAIN; // [R14]
      temperature_offset <= `MCAL_RST_TOFF; // [R14]
      current_gain <= `MCAL_RST_CURRENT_GAIN; // [R4]
      current_offset <= `MCAL_RST_CURRENT_OFFSET; // [R4]
      current_temp_coefficient <= `MCAL_RST_TEMPCO; // [R5]
      curvature_correction <= `MCAL_RST_CURVE;
      temp_path <= MCAL_PATH_INT;
    end
    else if (wr_ok)
    begin
      if (hit_temperature_gain)
        temperature_gain <= pwdata[15:0];
      if (hit_toff)
        temperature_offset <= pwdata[15:0];
      if (hit_current_gain)
        current_gain <= pwdata[15:0];
      if (hit_current_offset)
        current_offset <= pwdata[15:0];
      if (hit_tempco)
        current_temp_coefficient <= pwdata[15:0]; // [R7]
      if (hit_curve)
        curvature_correction <= pwdata[15:0];
      if (hit_config)
        temp_path <= mcal_path_t'(pwdata[`MCAL_CFG_EXT_BIT]);
    end
  end

  // Front end told which single path to convert
  assign temp_path_ext = (temp_path == MCAL_PATH_EXT); // [R10]

  ////////////////////////////////////////////////////////////////////
  // Curvature fields
  logic [7:0] metal_trace_curvature;
  logic [7:0] thermistor_curvature;

  assign metal_trace_curvature =
    curvature_correction[`MCAL_CURVE_METAL_MSB:`MCAL_CURVE_METAL_LSB]; // [R9]
  assign thermistor_curvature =
    curvature_correction[`MCAL_CURVE_THERM_MSB:`MCAL_CURVE_THERM_LSB]; // [R9]

  ////////////////////////////////////////////////////////////////////
  // Conversion acceptance; a done pulse for the idle path is dropped
  logic die_accept;
  logic ratio_accept;

  assign die_accept = die_temp_done && !temp_path_ext; // [R10]
  assign ratio_accept = ratio_done && temp_path_ext; // [R10]

  // Last die temperature kept for copper compensation
  always_ff @(posedge core_clk)
  begin
    if (srst)
      die_temp <= `MCAL_RST_DIE; // Room temperature until a reading comes
    else if (die_accept)
      die_temp <= die_temp_raw; // [R8]
  end

  // Ratio word stored as converted, 0.0122 percent steps
  always_ff @(posedge core_clk)
  begin
    if (srst)
      thermistor_ratio_result <= 16'h0000;
    else if (ratio_accept)
      thermistor_ratio_result <= ratio_raw; // [R11]
  end

  ////////////////////////////////////////////////////////////////////
  // Copper trace compensation ahead of gain and offset
  // Resistance rises with heat, so the correction is subtracted;
  // first-order only, good for a few tens of degrees of swing
  logic copper_mode;
  logic signed [16:0] temp_delta;
  logic signed [16:0] tempco_signed;
  logic signed [16:0] metal_signed;
  logic signed [16:0] raw_abs;
  logic signed [49:0] tempco_prod;
  logic signed [49:0] heat_prod;
  logic signed [49:0] comp_wide;
  logic signed [15:0] current_comp;

  assign copper_mode = (current_temp_coefficient != 16'h0000); // [R5]
  assign temp_delta = 17'(die_temp) - `MCAL_ROOM_TEMP; // [R8]
  assign tempco_signed = {1'b0, current_temp_coefficient}; // [R6]
  assign metal_signed = {9'h000, metal_trace_curvature};
  // One bit wider so full-scale negative still gives a positive magnitude
  assign raw_abs = current_raw[15] ? -17'(current_raw) : 17'(current_raw);
  assign tempco_prod = current_raw * tempco_signed * temp_delta; // [R6]
  assign heat_prod = current_raw * raw_abs * metal_signed; // [R8]
  assign comp_wide = 50'(current_raw)
    - (tempco_prod >>> `MCAL_TEMPCO_SH)
    - (heat_prod >>> `MCAL_HEAT_SH);
  assign current_comp = copper_mode
    ? mcal_sat16(comp_wide) : current_raw; // [R5]

  ////////////////////////////////////////////////////////////////////
  // Gain and offset of the current path, one cycle per conversion
  logic cur_valid;
  logic signed [15:0] cur_scaled;

  mcal_scale #(
    .IN_W(16),
    .SH(`MCAL_CURRENT_GAIN_SH)
  ) u_cur_scale (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(current_done), // [R19]
    .in_val(current_comp), // [R2]
    .gain(current_gain), // [R3]
    .offset(current_offset), // [R3]
    .out_valid(cur_valid),
    .out_val(cur_scaled)
  );

  // Signed result; charging reads positive
  assign current_result = cur_scaled; // [R1] [R17]

  ////////////////////////////////////////////////////////////////////
  // External temperature: linear stage, then curvature stage
  logic lin_valid;
  logic signed [15:0] temp_lin;
  logic signed [16:0] lin_dev;
  logic signed [49:0] curve_prod;
  logic signed [49:0] temp_curved;

  mcal_scale #(
    .IN_W(17),
    .SH(`MCAL_TEMPERATURE_GAIN_SH)
  ) u_temp_scale (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(ratio_accept), // [R19]
    .in_val({1'b0, ratio_raw}),
    .gain(temperature_gain), // [R12]
    .offset(temperature_offset), // [R12]
    .out_valid(lin_valid),
    .out_val(temp_lin)
  );

  // Second-order bend around room temperature
  assign lin_dev = 17'(temp_lin) - `MCAL_ROOM_TEMP;
  assign curve_prod = lin_dev * lin_dev
    * $signed({9'h000, thermistor_curvature}); // [R12]
  assign temp_curved = 50'(temp_lin)
    + (curve_prod >>> `MCAL_THERMISTOR_CURVATURE_SH); // [R12]

  // Internal path passes the die reading untouched
  always_ff @(posedge core_clk)
  begin
    if (srst)
      temperature_result <= 16'sh0000;
    else if (lin_valid && temp_path_ext)
      temperature_result <= mcal_sat16(temp_curved); // [R18]
    else if (die_accept)
      temperature_result <= die_temp_raw; // [R13]
  end

  ////////////////////////////////////////////////////////////////////
  // Battery voltage across battery pin and positive sense pin
  logic [16:0] volt_diff;

  assign volt_diff = {1'b0, battery_voltage_pin} - {1'b0, sense_pos_pin};

  // Negative difference clamps to zero
  always_ff @(posedge core_clk)
  begin
    if (srst)
      voltage_result <= 16'h0000;
    else if (voltage_done)
      voltage_result <= volt_diff[16] ? 16'h0000 : volt_diff[15:0]; // [R15]
  end

  ////////////////////////////////////////////////////////////////////
  // Checks
  a_cur_reset: assert property ( // [R4]
    @(posedge core_clk) srst |=> (current_gain == `MCAL_RST_CURRENT_GAIN)
      && (current_offset == `MCAL_RST_CURRENT_OFFSET))
  else $error("current gain or offset wrong after reset");

  a_temp_reset: assert property ( // [R14]
    @(posedge core_clk) srst |=> (temperature_gain == `MCAL_RST_TEMPERATURE_GAIN)
      && (temperature_offset == `MCAL_RST_TOFF))
  else $error("temperature gain or offset wrong after reset");

  a_tempco_off: assert property ( // [R5]
    @(posedge core_clk) disable iff (srst)
      !copper_mode |-> (current_comp == current_raw))
  else $error("compensation active with zero coefficient");

  a_cur_formula: assert property ( // [R3]
    @(posedge core_clk) disable iff (srst)
      (current_done && !copper_mode && !wr_ok) |=>
      (current_result == mcal_sat16(
        50'((50'($past(current_raw)) * 50'($signed(current_gain)))
          >>> `MCAL_CURRENT_GAIN_SH) + 50'($signed(current_offset)))))
  else $error("current result does not follow gain and offset");

  a_cur_sign: assert property ( // [R1]
    @(posedge core_clk) disable iff (srst)
      (current_done && !copper_mode && current_gain == `MCAL_RST_CURRENT_GAIN
      && current_offset == `MCAL_RST_CURRENT_OFFSET && !wr_ok)
      |=> (current_result == $past(current_raw)))
  else $error("default calibration changed raw current");

  a_path_single: assert property ( // [R10]
    @(posedge core_clk) disable iff (srst)
      (ratio_done && !temp_path_ext) |=> $stable(thermistor_ratio_result))
  else $error("ratio taken while internal path selected");

  a_ratio_store: assert property ( // [R11]
    @(posedge core_clk) disable iff (srst)
      ratio_accept |=> (thermistor_ratio_result == $past(ratio_raw)))
  else $error("ratio word not stored");

  a_int_bypass: assert property ( // [R13]
    @(posedge core_clk) disable iff (srst)
      (die_accept && !lin_valid) |=> (temperature_result == $past(die_temp_raw)))
  else $error("internal temperature was altered");

  a_ext_latency: assert property ( // [R19]
    @(posedge core_clk) disable iff (srst)
      (ratio_accept ##1 temp_path_ext) |-> lin_valid
        ##1 (temperature_result == $past(mcal_sat16(temp_curved))))
  else $error("external temperature not recomputed");

  a_volt_diff: assert property ( // [R15]
    @(posedge core_clk) disable iff (srst)
      (voltage_done && battery_voltage_pin >= sense_pos_pin) |=>
      (voltage_result == $past(battery_voltage_pin) - $past(sense_pos_pin)))
  else $error("battery voltage difference wrong");

  a_apb_error: assert property (
    @(posedge core_clk) disable iff (srst)
      (psel && penable && !hit_any) |=> $stable({temperature_gain, temperature_offset,
        current_gain, current_offset, current_temp_coefficient, curvature_correction, temp_path}))
  else $error("unmapped write changed a register");
endmodule

// >>> rtl/mcal_map.svh
// Purpose: constants for the measurement calibration block
// Assumes: register index times four gives the APB byte address
// Notes: shift counts set the fixed-point scaling of each path
`ifndef MCAL_MAP_SVH
`define MCAL_MAP_SVH
// Register indices
`define MCAL_IDX_TEMP_RES 8'h08
`define MCAL_IDX_VOLT_RES 8'h09
`define MCAL_IDX_CUR_RES 8'h0A
`define MCAL_IDX_CONFIG 8'h1D
`define MCAL_IDX_RATIO 8'h27
`define MCAL_IDX_TEMPERATURE_GAIN 8'h2C
`define MCAL_IDX_TOFF 8'h2D
`define MCAL_IDX_CURRENT_GAIN 8'h2E
`define MCAL_IDX_CURRENT_OFFSET 8'h2F
`define MCAL_IDX_TEMPCO 8'hB8
`define MCAL_IDX_CURVE 8'hB9
// Reset values
`define MCAL_RST_TEMPERATURE_GAIN 16'hEE56
`define MCAL_RST_TOFF 16'h1DA4
`define MCAL_RST_CURRENT_GAIN 16'h0400
`define MCAL_RST_CURRENT_OFFSET 16'h0000
`define MCAL_RST_TEMPCO 16'h0000
`define MCAL_RST_CURVE 16'h0025
`define MCAL_RST_DIE 16'sh1900
// Fields
`define MCAL_CFG_EXT_BIT 0
`define MCAL_CURVE_METAL_MSB 15
`define MCAL_CURVE_METAL_LSB 8
`define MCAL_CURVE_THERM_MSB 7
`define MCAL_CURVE_THERM_LSB 0
// Scaling
`define MCAL_CURRENT_GAIN_SH 10
`define MCAL_TEMPERATURE_GAIN_SH 10
`define MCAL_TEMPCO_SH 29
`define MCAL_HEAT_SH 26
`define MCAL_THERMISTOR_CURVATURE_SH 24
`define MCAL_ROOM_TEMP 17'sh01900
`endif

// >>> rtl/mcal_pkg.sv
// Purpose: shared types for the measurement calibration block
// Assumes: results are 16-bit words
// Notes: saturation keeps results inside the signed word
package mcal_pkg;
  typedef logic [15:0] mcal_word_t;
  typedef enum logic
  {
    MCAL_PATH_INT = 1'b0,
    MCAL_PATH_EXT = 1'b1
  } mcal_path_t;

  // Clamp a wide signed value to a signed 16-bit word
  function automatic mcal_word_t mcal_sat16(input logic signed [49:0] v);
    if (v > 50'sh7FFF)
    begin
      return 16'h7FFF;
    end
    if (v < -50'sh8000)
    begin
      return 16'h8000;
    end
    return v[15:0];
  endfunction
endpackage

// >>> rtl/mcal_scale.sv
// Purpose: registered gain, shift, offset and clamp stage
// Assumes: gain and offset are signed words
// Notes: one cycle from in_valid to out_valid
`timescale 1ns/100ps
module mcal_scale
  import mcal_pkg::*;
#(
  parameter int IN_W = 16,
  parameter int SH = 10
)
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic in_valid,
  input wire logic signed [IN_W-1:0] in_val,
  input wire logic signed [15:0] gain,
  input wire logic signed [15:0] offset,
  output logic out_valid,
  output logic signed [15:0] out_val
);
  localparam int PW = IN_W + 16;

  generate
    if (IN_W < 2 || IN_W > 32 || SH >= PW)
    begin : g_bad
      $error("mcal_scale: unsupported width or shift");
    end
  endgenerate

  logic signed [PW-1:0] prod;
  logic signed [PW:0] sum;

  // Product, scale, then offset
  assign prod = in_val * gain;
  assign sum = (PW+1)'(prod >>> SH) + (PW+1)'(offset);

  // Result held until the next conversion
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      out_valid <= 1'b0;
      out_val <= 16'h0000;
    end
    else
    begin
      out_valid <= in_valid;
      if (in_valid)
        out_val <= mcal_sat16(50'(sum));
    end
  end
endmodule

// >>> bench/mcal_front_model.sv
// Purpose: stand-in for sense resistor, thermistor divider and pins
// Assumes: the bench asks for one conversion at a time
// Notes: raw words go stale (inverted) once their done pulse ends
`timescale 1ns/100ps
module mcal_front_model
(
  input wire logic core_clk,
  output logic [15:0] cur_raw,
  output logic [15:0] die_raw,
  output logic [15:0] ratio_raw,
  output logic [15:0] vbat,
  output logic [15:0] vsp,
  output logic [3:0] done
);
  initial
  begin
    {cur_raw, die_raw, ratio_raw, vbat, vsp} = '0;
    done = 4'h0;
  end

  // Kind 0 current, 1 die, 2 ratio, 3 voltage pins
  task automatic convert(input int kind, input logic [15:0] a, input logic [15:0] b);
    @(posedge core_clk);
    done <= 4'h1 << kind;
    if (kind == 0) cur_raw <= a; // Positive while charging, full signed span
    if (kind == 1) die_raw <= a;
    if (kind == 2) ratio_raw <= a; // Divider ratio, 0 to 100 percent
    if (kind == 3) vbat <= a; // Battery pin against positive sense pin
    if (kind == 3) vsp <= b;
    @(posedge core_clk);
    done <= 4'h0;
    // Stale data must not pass for a held value
    {cur_raw, die_raw, ratio_raw, vbat, vsp} <= ~{cur_raw, die_raw, ratio_raw, vbat, vsp};
  endtask
endmodule

// >>> bench/measurement_calibration_tb.sv
// Purpose: self-checking bench for the calibration core
// Assumes: zero wait-state APB, one conversion at a time
// Notes: expectations follow the documented scaling formulas
`timescale 1ns/100ps
`include "mcal_map.svh"
module measurement_calibration_tb;
  logic core_clk, srst, psel, penable, pwrite, pready, pslverr, temp_path_ext, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] cur_raw, die_raw, ratio_raw, vbat, vsp, cur_res, temp_res, volt_res;
  logic [15:0] v, w, cg, co, tc, cv, tg, to, die;
  logic [3:0] done;
  int fails, compares, cycles;
  logic [7:0] ridx[6] = '{`MCAL_IDX_TEMPERATURE_GAIN, `MCAL_IDX_TOFF, `MCAL_IDX_CURRENT_GAIN, `MCAL_IDX_CURRENT_OFFSET,
    `MCAL_IDX_TEMPCO, `MCAL_IDX_CURVE};
  logic [15:0] rval[6] = '{16'hEE56, 16'h1DA4, 16'h0400, 16'h0000, 16'h0000, 16'h0025};

  mcal_core dut_u
  (
    .core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .current_raw(cur_raw), .current_done(done[0]), .die_temp_raw(die_raw), .die_temp_done(done[1]),
    .ratio_raw(ratio_raw), .ratio_done(done[2]), .battery_voltage_pin(vbat), .sense_pos_pin(vsp),
    .voltage_done(done[3]), .temp_path_ext(temp_path_ext), .current_result(cur_res),
    .temperature_result(temp_res), .voltage_result(volt_res)
  );

  mcal_front_model front_u
  (
    .core_clk(core_clk), .cur_raw(cur_raw), .die_raw(die_raw), .ratio_raw(ratio_raw),
    .vbat(vbat), .vsp(vsp), .done(done)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [15:0] wd);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, wd};
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    // Ends at the first edge that sees pready high; only the hang guard ends a wait that never does
    while (pready !== 1'b1)
    begin
      @(posedge core_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [15:0] exp);
    apb(1'b0, idx, 16'h0000);
    chk_word($sformatf("register %h", idx), exp, rd[15:0]);
  endtask

  // Conversion; results are looked at once the answering edge has landed
  task automatic conv(input int kind, input logic [15:0] a, input logic [15:0] b);
    front_u.convert(kind, a, b);
    if (kind == 2) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [15:0] sat(input longint x);
    if (x > 32767) return 16'h7FFF;
    if (x < -32768) return 16'h8000;
    return x[15:0];
  endfunction

  // Copper compensation only while the coefficient is nonzero
  function automatic logic [15:0] cur_exp(input logic [15:0] raw);
    longint r, c;
    r = longint'($signed(raw));
    c = r;
    if (tc != 16'h0000)
      c = r - ((r * longint'(tc) * (longint'($signed(die)) - 6400)) >>> 29)
        - ((r * (r < 0 ? -r : r) * longint'(cv[15:8])) >>> 26);
    c = longint'($signed(sat(c)));
    return sat(((c * longint'($signed(cg))) >>> 10) + longint'($signed(co)));
  endfunction

  function automatic logic [15:0] temp_exp(input logic [15:0] ratio);
    longint l;
    l = ((longint'(ratio) * longint'($signed(tg))) >>> 10) + longint'($signed(to));
    l = longint'($signed(sat(l)));
    return sat(l + (((l - 6400) * (l - 6400) * longint'(cv[7:0])) >>> 24));
  endfunction

  ////////////////////////////////////////////////////////////////////
  initial
  begin
    {srst, psel, penable, pwrite, paddr, pwdata} = '0;
    srst = 1'b1;
    {fails, compares, cycles} = '0;
    {cg, co, tc, cv, tg, to, die} = {16'h0400, 16'h0000, 16'h0000, 16'h0025, 16'hEE56, 16'h1DA4, 16'h1900};
    void'($urandom(32'h8682));
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    // Reset values, then random write and read back
    for (int i = 0; i < 6; i++) rd_chk(ridx[i], rval[i]);
    for (int i = 0; i < 6; i++)
    begin
      v = $urandom;
      apb(1'b1, ridx[i], v);
      rd_chk(ridx[i], v);
      apb(1'b1, ridx[i], rval[i]);
    end
    // Unmapped write is dropped with an error; read answers error and zero data
    apb(1'b1, 8'h10, 16'hFFFF);
    chk_word("unmapped write error", 16'h0001, {15'h0000, err});
    apb(1'b0, 8'h10, 16'h0000);
    chk_word("unmapped error", 16'h0001, {15'h0000, err});
    chk_word("unmapped data", 16'h0000, rd[15:0]);
    // Default gains pass the raw word through, sign kept
    for (int i = 0; i < 5; i++)
    begin
      v = (i == 4) ? 16'($urandom) : (i == 0 ? 16'h7FFF : (i == 1 ? 16'h8000 : (i == 2 ? 16'h0001 : 16'hFFFF)));
      conv(0, v, 16'h0000);
      chk_word("current", v, cur_res);
    end
    rd_chk(`MCAL_IDX_CUR_RES, v);
    // Random gain and offset, each conversion under the settings of its moment
    repeat (8)
    begin
      cg = 16'($urandom_range(16'h7FFF));
      co = $urandom;
      apb(1'b1, `MCAL_IDX_CURRENT_GAIN, cg);
      apb(1'b1, `MCAL_IDX_CURRENT_OFFSET, co);
      v = $urandom;
      conv(0, v, 16'h0000);
      chk_word("scaled current", cur_exp(v), cur_res);
    end
    // Copper trace: die reading, coefficient and metal curvature
    die = 16'h2300;
    conv(1, die, 16'h0000);
    chk_word("internal temp", die, temp_res);
    tc = 16'h20C8;
    cv = 16'h1025;
    apb(1'b1, `MCAL_IDX_TEMPCO, tc);
    apb(1'b1, `MCAL_IDX_CURVE, cv);
    repeat (4)
    begin
      v = 16'($urandom_range(16'h4000));
      conv(0, v, 16'h0000);
      chk_word("copper current", cur_exp(v), cur_res);
    end
    tc = 16'h0000;
    apb(1'b1, `MCAL_IDX_TEMPCO, tc);
    conv(0, v, 16'h0000);
    chk_word("uncompensated current", cur_exp(v), cur_res);
    // External thermistor path; die readings are dropped
    apb(1'b1, 8'(`MCAL_IDX_CONFIG), 16'h0001);
    #1;
    chk_word("ext path", 16'h0001, {15'h0000, temp_path_ext});
    conv(1, 16'h0BAD, 16'h0000);
    chk_word("dropped die", die, temp_res);
    for (int i = 0; i < 6; i++)
    begin
      if (i == 3)
      begin
        {tg, to, cv} = {16'hF49A, 16'h16A1, 16'h1064};
        apb(1'b1, `MCAL_IDX_TEMPERATURE_GAIN, tg);
        apb(1'b1, `MCAL_IDX_TOFF, to);
        apb(1'b1, `MCAL_IDX_CURVE, cv);
      end
      w = 16'($urandom_range(16'h0A00));
      conv(2, w, 16'h0000);
      chk_word("ext temp", temp_exp(w), temp_res);
      rd_chk(`MCAL_IDX_RATIO, w);
    end
    // Back to internal: gain, offset and curve play no part
    apb(1'b1, 8'(`MCAL_IDX_CONFIG), 16'h0000);
    #1;
    chk_word("int path", 16'h0000, {15'h0000, temp_path_ext});
    // Thermistor done pulse is dropped while the die path runs
    conv(2, 16'h0BAD, 16'h0000);
    rd_chk(`MCAL_IDX_RATIO, w);
    die = 16'hF380;
    conv(1, die, 16'h0000);
    chk_word("internal temp", die, temp_res);
    // Battery voltage is the pin difference, floored at zero
    for (int i = 0; i < 6; i++)
    begin
      v = $urandom;
      w = (i == 0) ? v : 16'($urandom);
      conv(3, v, w);
      chk_word("voltage", (v > w) ? v - w : 16'h0000, volt_res);
    end
    give_verdict();
  end
endmodule
